// ---- shared/accel_cfg_defs.svh ----
`ifndef ACCEL_CFG_DEFS_SVH
`define ACCEL_CFG_DEFS_SVH

// register byte offsets (printed offsets not all multiples of four: index * 4)
`define IDX_ACC_X_LSB       8'h02
`define IDX_ACC_X_MSB       8'h03
`define IDX_ACC_Y_LSB       8'h04
`define IDX_ACC_Y_MSB       8'h05
`define IDX_ACC_Z_LSB       8'h06
`define IDX_ACC_Z_MSB       8'h07
`define IDX_FULL_SCALE      8'h0f
`define IDX_BANDWIDTH       8'h10
`define IDX_POWER           8'h11
`define IDX_RESERVED_A      8'h12
`define IDX_ACQUISITION     8'h13
`define IDX_SOFT_RESET      8'h14
`define IDX_RESERVED_B      8'h15
`define IDX_EN_MOTION       8'h16
`define IDX_EN_LEVEL        8'h17
`define IDX_RESERVED_C      8'h18
`define IDX_PIN_ONE_ROUTE   8'h19
`define IDX_NEW_SAMPLE_RTE  8'h1a
`define IDX_PIN_TWO_ROUTE   8'h1b
`define IDX_PIN_LEVEL       8'h20

// writable masks: reserved bits ignore writes, read zero
`define MASK_FULL_SCALE     8'h0f
`define MASK_BANDWIDTH      8'h1f
`define MASK_POWER          8'hde
`define MASK_ACQUISITION    8'hc0
`define MASK_EN_MOTION      8'hf7
`define MASK_EN_LEVEL       8'h1f
`define MASK_PIN_ROUTE      8'hf7
`define MASK_NEW_SAMPLE_RTE 8'h81
`define MASK_PIN_LEVEL      8'h05

// reset values
`define RST_FULL_SCALE      8'h03
`define RST_BANDWIDTH       8'h1f
`define RST_ZERO            8'h00
`define RST_PIN_LEVEL       8'h05

// field positions
`define BIT_SUSPEND         7
`define BIT_LOW_POWER       6
`define BIT_SLEEP_LO        1
`define BIT_UNFILTERED      7
`define BIT_SHADOW_DIS      6
`define BIT_ROUTE_NEW_TWO   7
`define BIT_ROUTE_NEW_ONE   0
`define BIT_LVL_ONE         0
`define BIT_LVL_TWO         2
`define BIT_EN_NEW_SAMPLE   4
`define BIT_EN_FREEFALL     3

`define SOFT_RESET_KEY      8'hb6

// sleep durations in microseconds, per code 0..15
`define SLEEP_US_0_5MS      32'd500
`define SLEEP_US_1MS        32'd1000
`define SLEEP_US_2MS        32'd2000
`define SLEEP_US_4MS        32'd4000
`define SLEEP_US_6MS        32'd6000
`define SLEEP_US_10MS       32'd10000
`define SLEEP_US_25MS       32'd25000
`define SLEEP_US_50MS       32'd50000
`define SLEEP_US_100MS      32'd100000
`define SLEEP_US_500MS      32'd500000
`define SLEEP_US_1S         32'd1000000
`define CLK_MHZ             32'd20

`endif

// ---- shared/accel_cfg_pkg.sv ----
package accel_cfg_pkg;

    typedef enum logic [1:0] {
        RANGE_2G,
        RANGE_4G,
        RANGE_8G,
        RANGE_16G
    } g_range_t;

    typedef enum logic [2:0] {
        FILT_7HZ81,
        FILT_15HZ63,
        FILT_31HZ25,
        FILT_62HZ5,
        FILT_125HZ,
        FILT_250HZ,
        FILT_1000HZ
    } bandwidth_t;

    typedef enum logic [1:0] {
        PWR_NORMAL,
        PWR_LOW,
        PWR_SUSPEND
    } power_state_t;

endpackage

// ---- verilog/accel_mode_decode.sv ----
`timescale 1ns/1ps
`include "accel_cfg_defs.svh"

module accel_mode_decode (
    input  wire logic [3:0]               fullScaleCode,
    input  wire logic [4:0]               filterBandwidthCode,
    input  wire logic [3:0]               sleepCode,
    output accel_cfg_pkg::g_range_t       gRange,
    output accel_cfg_pkg::bandwidth_t     bandwidth,
    output logic      [31:0]              sleepCycles
);

    always_comb begin
        unique case (fullScaleCode)
            4'h3:    gRange = accel_cfg_pkg::RANGE_2G;  // [R1]
            4'h5:    gRange = accel_cfg_pkg::RANGE_4G;  // [R1]
            4'h8:    gRange = accel_cfg_pkg::RANGE_8G;  // [R1]
            4'hc:    gRange = accel_cfg_pkg::RANGE_16G; // [R1]
            default: gRange = accel_cfg_pkg::RANGE_2G;  // [R2]
        endcase
    end

    // 01110b is left undefined; treated as the widest filter
    always_comb begin
        if (filterBandwidthCode[4]) begin
            bandwidth = accel_cfg_pkg::FILT_1000HZ; // [R4]
        end else if (!filterBandwidthCode[3]) begin
            bandwidth = accel_cfg_pkg::FILT_7HZ81; // [R4]
        end else begin
            unique case (filterBandwidthCode[2:0])
                3'h0:    bandwidth = accel_cfg_pkg::FILT_7HZ81;  // [R4]
                3'h1:    bandwidth = accel_cfg_pkg::FILT_15HZ63; // [R4]
                3'h2:    bandwidth = accel_cfg_pkg::FILT_31HZ25; // [R4]
                3'h3:    bandwidth = accel_cfg_pkg::FILT_62HZ5;  // [R4]
                3'h4:    bandwidth = accel_cfg_pkg::FILT_125HZ;  // [R4]
                3'h5:    bandwidth = accel_cfg_pkg::FILT_250HZ;  // [R4]
                default: bandwidth = accel_cfg_pkg::FILT_1000HZ; // [R4]
            endcase
        end
    end

    always_comb begin
        unique case (sleepCode)
            4'h6:    sleepCycles = `SLEEP_US_1MS * `CLK_MHZ;   // [R9]
            4'h7:    sleepCycles = `SLEEP_US_2MS * `CLK_MHZ;   // [R9]
            4'h8:    sleepCycles = `SLEEP_US_4MS * `CLK_MHZ;   // [R9]
            4'h9:    sleepCycles = `SLEEP_US_6MS * `CLK_MHZ;   // [R9]
            4'ha:    sleepCycles = `SLEEP_US_10MS * `CLK_MHZ;  // [R9]
            4'hb:    sleepCycles = `SLEEP_US_25MS * `CLK_MHZ;  // [R9]
            4'hc:    sleepCycles = `SLEEP_US_50MS * `CLK_MHZ;  // [R9]
            4'hd:    sleepCycles = `SLEEP_US_100MS * `CLK_MHZ; // [R9]
            4'he:    sleepCycles = `SLEEP_US_500MS * `CLK_MHZ; // [R9]
            4'hf:    sleepCycles = `SLEEP_US_1S * `CLK_MHZ;    // [R9]
            default: sleepCycles = `SLEEP_US_0_5MS * `CLK_MHZ; // [R9]
        endcase
    end

endmodule

// ---- verilog/accel_irq_route.sv ----
`timescale 1ns/1ps
`include "accel_cfg_defs.svh"

module accel_irq_route (
    input  wire logic [7:0] motionStatus,
    input  wire logic       newSampleStatus,
    input  wire logic [7:0] enMotion,
    input  wire logic [7:0] enLevel,
    input  wire logic [7:0] pinRoute,
    input  wire logic       newSampleRoute,
    input  wire logic       activeHigh,
    output logic            pinLevel
);

    logic [7:0] gated;
    logic       any;

    // folds per-axis enables onto the single status bit of sources 2 and 1
    always_comb begin
        gated[7:4] = motionStatus[7:4] & enMotion[7:4];
        gated[3]   = 1'b0;
        gated[2]   = motionStatus[2] & |enMotion[2:0];
        gated[1]   = motionStatus[1] & |enLevel[2:0];
        gated[0]   = motionStatus[0] & enLevel[`BIT_EN_FREEFALL];
        any        = |(gated & pinRoute) | (newSampleStatus & enLevel[`BIT_EN_NEW_SAMPLE] & newSampleRoute); // [R25]
        pinLevel   = activeHigh ? any : ~any; // [R24]
    end

endmodule

// ---- verilog/accel_config_irq_routing.sv ----
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "accel_cfg_defs.svh"

// Contract
// [R1] range codes 3,5,8,c give 2/4/8/16g
// [R2] any other range code gives 2g
// [R3] range field resets to 0011b
// [R4] bandwidth code decodes to filter frequency
// [R5] bandwidth field resets to 11111b
// [R6] host should use bandwidth 01000b-01111b
// [R7] power bit 7 selects suspend, reset zero
// [R8] power bit 6 selects low-power, reset zero
// [R9] sleep field sets low-power sleep duration
// [R10] sleep field resets to 0000b
// [R11] output bit picks filtered or unfiltered data
// [R12] shadowing: msb refreshes on lsb read
// [R13] writing b6 to soft reset resets all
// [R14] soft reset register reads zero
// [R15] first enable register bit meanings
// [R16] second enable register bit meanings
// [R17] all enables reset to zero
// [R18] pin one routing register bit meanings
// [R19] new-data routing bit 7 pin two, bit 0 pin one
// [R20] pin two routing, same bit positions
// [R21] all routing bits reset to zero
// [R22] 0x12, 0x15, 0x18 reserved
// [R23] 10-bit sample split over lsb and msb
// [R24] per-pin level bit, default active high
// [R25] pin asserts on enabled and mapped source
// [R26] reserved bits ignore writes, read zero
module accel_config_irq_routing (
    input  wire logic                   sys_clk,
    input  wire logic                   sys_rst,
    input  wire logic [7:0]             paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [29:0]            filteredSample,
    input  wire logic [29:0]            unfilteredSample,
    input  wire logic                   sampleStrobe,
    input  wire logic [7:0]             motionStatus,
    input  wire logic                   newSampleStatus,
    output logic                        irq_pin_one,
    output logic                        irq_pin_two,
    output accel_cfg_pkg::g_range_t     gRange,
    output accel_cfg_pkg::bandwidth_t   bandwidth,
    output accel_cfg_pkg::power_state_t powerState,
    output logic                        sleepPhase
);

    logic [7:0]  fullScale;
    logic [7:0]  filter_bandwidth_code;
    logic [7:0]  powerMode;
    logic [7:0]  acquisition;
    logic [7:0]  enMotion;
    logic [7:0]  enLevel;
    logic [7:0]  pinOneRoute;
    logic [7:0]  newSampleRoute;
    logic [7:0]  pinTwoRoute;
    logic [7:0]  pinLevelCfg;
    logic [29:0] liveSample;
    logic [2:0]  newFlag;
    logic [7:0]  msbShadow [3];
    logic [31:0] sleepCycles;
    logic [31:0] powerCount;
    logic        rdStrobe;
    logic        wrStrobe;
    logic        softReset;
    logic        regReset;
    logic        known;
    logic        lineOne;
    logic        lineTwo;
    logic [7:0]  next_rdata;
    logic [5:0]  regIdx;
    accel_cfg_pkg::g_range_t   decRange;
    accel_cfg_pkg::bandwidth_t decBand;

    function automatic logic isIdx(input logic [7:0] addr, input logic [7:0] idx);
        isIdx = (addr[1:0] == 2'h0) && (addr[7:2] == idx[5:0]);
    endfunction

    assign rdStrobe  = psel && penable && !pwrite;
    assign wrStrobe  = psel && penable && pwrite && pstrb[0];
    assign regIdx    = paddr[7:2];
    assign softReset = wrStrobe && isIdx(paddr, `IDX_SOFT_RESET) && pwdata[7:0] == `SOFT_RESET_KEY; // [R13]
    assign regReset  = sys_rst || softReset; // [R13]

    always_ff @(posedge sys_clk) begin
        if (regReset) begin
            fullScale             <= `RST_FULL_SCALE; // [R3]
            filter_bandwidth_code <= `RST_BANDWIDTH;  // [R5]
            powerMode             <= `RST_ZERO;       // [R7] [R8] [R10]
            acquisition           <= `RST_ZERO;       // [R11] [R12]
            enMotion              <= `RST_ZERO;       // [R17]
            enLevel               <= `RST_ZERO;       // [R17]
            pinOneRoute           <= `RST_ZERO;       // [R21]
            newSampleRoute        <= `RST_ZERO;       // [R21]
            pinTwoRoute           <= `RST_ZERO;       // [R21]
            pinLevelCfg           <= `RST_PIN_LEVEL;  // [R24]
        end else if (wrStrobe) begin
            // reserved offsets fall through with no effect
            if (isIdx(paddr, `IDX_FULL_SCALE))     fullScale <= pwdata[7:0] & `MASK_FULL_SCALE; // [R26]
            if (isIdx(paddr, `IDX_BANDWIDTH))      filter_bandwidth_code <= pwdata[7:0] & `MASK_BANDWIDTH; // [R26]
            if (isIdx(paddr, `IDX_POWER))          powerMode <= pwdata[7:0] & `MASK_POWER; // [R7] [R8] [R9]
            if (isIdx(paddr, `IDX_ACQUISITION))    acquisition <= pwdata[7:0] & `MASK_ACQUISITION; // [R11] [R12]
            if (isIdx(paddr, `IDX_EN_MOTION))      enMotion <= pwdata[7:0] & `MASK_EN_MOTION; // [R15]
            if (isIdx(paddr, `IDX_EN_LEVEL))       enLevel <= pwdata[7:0] & `MASK_EN_LEVEL; // [R16]
            if (isIdx(paddr, `IDX_PIN_ONE_ROUTE))  pinOneRoute <= pwdata[7:0] & `MASK_PIN_ROUTE; // [R18]
            if (isIdx(paddr, `IDX_NEW_SAMPLE_RTE)) newSampleRoute <= pwdata[7:0] & `MASK_NEW_SAMPLE_RTE; // [R19]
            if (isIdx(paddr, `IDX_PIN_TWO_ROUTE))  pinTwoRoute <= pwdata[7:0] & `MASK_PIN_ROUTE; // [R20]
            if (isIdx(paddr, `IDX_PIN_LEVEL))      pinLevelCfg <= pwdata[7:0] & `MASK_PIN_LEVEL; // [R24]
        end
    end

    assign liveSample = acquisition[`BIT_UNFILTERED] ? unfilteredSample : filteredSample; // [R11]

    // per-axis data: lsb {d1,d0,0000 0,flag}, msb d9..d2
    genvar ax;
    generate
        for (ax = 0; ax < 3; ax++) begin : g_axis
            logic [9:0] axisData;
            logic       lsbRead;
            assign axisData = liveSample[ax*10 +: 10];
            assign lsbRead  = rdStrobe && isIdx(paddr, 8'(`IDX_ACC_X_LSB + 2 * ax));
            always_ff @(posedge sys_clk) begin
                if (regReset) begin
                    newFlag[ax] <= 1'b0;
                end else if (sampleStrobe) begin
                    newFlag[ax] <= 1'b1; // set wins over the read clear
                end else if (lsbRead) begin
                    newFlag[ax] <= 1'b0;
                end
            end
            always_ff @(posedge sys_clk) begin
                if (regReset) begin
                    msbShadow[ax] <= 8'h00;
                end else if (lsbRead || acquisition[`BIT_SHADOW_DIS]) begin
                    msbShadow[ax] <= axisData[9:2]; // [R12] [R23]
                end
            end
        end
    endgenerate

    always_comb begin
        next_rdata = 8'h00;
        known      = 1'b1;
        unique case ({2'h0, regIdx})
            `IDX_ACC_X_LSB:      next_rdata = {liveSample[1:0], 5'h00, newFlag[0]}; // [R23]
            `IDX_ACC_X_MSB:      next_rdata = msbShadow[0]; // [R12]
            `IDX_ACC_Y_LSB:      next_rdata = {liveSample[11:10], 5'h00, newFlag[1]}; // [R23]
            `IDX_ACC_Y_MSB:      next_rdata = msbShadow[1];
            `IDX_ACC_Z_LSB:      next_rdata = {liveSample[21:20], 5'h00, newFlag[2]}; // [R23]
            `IDX_ACC_Z_MSB:      next_rdata = msbShadow[2];
            `IDX_FULL_SCALE:     next_rdata = fullScale;
            `IDX_BANDWIDTH:      next_rdata = filter_bandwidth_code;
            `IDX_POWER:          next_rdata = powerMode;
            `IDX_ACQUISITION:    next_rdata = acquisition;
            `IDX_SOFT_RESET:     next_rdata = 8'h00; // [R14]
            `IDX_EN_MOTION:      next_rdata = enMotion;
            `IDX_EN_LEVEL:       next_rdata = enLevel;
            `IDX_PIN_ONE_ROUTE:  next_rdata = pinOneRoute;
            `IDX_NEW_SAMPLE_RTE: next_rdata = newSampleRoute;
            `IDX_PIN_TWO_ROUTE:  next_rdata = pinTwoRoute;
            `IDX_PIN_LEVEL:      next_rdata = pinLevelCfg;
            `IDX_RESERVED_A, `IDX_RESERVED_B, `IDX_RESERVED_C: next_rdata = 8'h00; // [R22]
            default:             known = 1'b0;
        endcase
        if (paddr[1:0] != 2'h0) begin
            known = 1'b0;
        end
    end

    // zero-wait slave: answer captured in setup, shown through the single access cycle
    // read data predates the lsb read side effects of the same transfer
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !known;
            prdata  <= {24'h000000, next_rdata};
        end
    end

    accel_mode_decode modeDecode (
        .fullScaleCode       (fullScale[3:0]),
        .filterBandwidthCode (filter_bandwidth_code[4:0]),
        .sleepCode           (powerMode[4:1]),
        .gRange              (decRange),
        .bandwidth           (decBand),
        .sleepCycles         (sleepCycles)
    );

    accel_irq_route routeOne (
        .motionStatus    (motionStatus),
        .newSampleStatus (newSampleStatus),
        .enMotion        (enMotion),
        .enLevel         (enLevel),
        .pinRoute        (pinOneRoute),
        .newSampleRoute  (newSampleRoute[`BIT_ROUTE_NEW_ONE]),
        .activeHigh      (pinLevelCfg[`BIT_LVL_ONE]),
        .pinLevel        (lineOne)
    );

    accel_irq_route routeTwo (
        .motionStatus    (motionStatus),
        .newSampleStatus (newSampleStatus),
        .enMotion        (enMotion),
        .enLevel         (enLevel),
        .pinRoute        (pinTwoRoute),
        .newSampleRoute  (newSampleRoute[`BIT_ROUTE_NEW_TWO]),
        .activeHigh      (pinLevelCfg[`BIT_LVL_TWO]),
        .pinLevel        (lineTwo)
    );

    always_ff @(posedge sys_clk) begin
        if (regReset) begin
            irq_pin_one <= 1'b0;
            irq_pin_two <= 1'b0;
        end else begin
            irq_pin_one <= lineOne; // [R25]
            irq_pin_two <= lineTwo; // [R25]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (regReset) begin
            gRange    <= accel_cfg_pkg::RANGE_2G;
            bandwidth <= accel_cfg_pkg::FILT_1000HZ;
        end else begin
            gRange    <= decRange;  // [R1] [R2]
            bandwidth <= decBand;   // [R4]
        end
    end

    // suspend outranks low power
    always_ff @(posedge sys_clk) begin
        if (regReset) begin
            powerState <= accel_cfg_pkg::PWR_NORMAL;
        end else if (powerMode[`BIT_SUSPEND]) begin
            powerState <= accel_cfg_pkg::PWR_SUSPEND; // [R7]
        end else if (powerMode[`BIT_LOW_POWER]) begin
            powerState <= accel_cfg_pkg::PWR_LOW; // [R8]
        end else begin
            powerState <= accel_cfg_pkg::PWR_NORMAL;
        end
    end

    // sleep timer alternates sleep and one-cycle wake in low-power mode
    always_ff @(posedge sys_clk) begin
        if (regReset || powerState != accel_cfg_pkg::PWR_LOW) begin
            powerCount <= 32'h0;
            sleepPhase <= 1'b0;
        end else if (powerCount + 32'h1 >= sleepCycles) begin
            powerCount <= 32'h0; // [R9]
            sleepPhase <= 1'b0;
        end else begin
            powerCount <= powerCount + 32'h1;
            sleepPhase <= 1'b1;
        end
    end

    range_reset_a: assert property (@(posedge sys_clk) // [R3]
        sys_rst |=> fullScale == `RST_FULL_SCALE && gRange == accel_cfg_pkg::RANGE_2G)
        else $error("range not 2g after reset");
    bw_reset_a: assert property (@(posedge sys_clk) sys_rst |=> filter_bandwidth_code == `RST_BANDWIDTH) // [R5]
        else $error("bandwidth not default after reset");
    new_route_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R19]
        newSampleStatus && enLevel[`BIT_EN_NEW_SAMPLE] && newSampleRoute[`BIT_ROUTE_NEW_TWO]
        && pinLevelCfg[`BIT_LVL_TWO] && !softReset |=> irq_pin_two)
        else $error("new sample not on pin two");
    soft_reset_a: assert property (@(posedge sys_clk) disable iff (sys_rst) softReset |=> fullScale == 8'h03 && filter_bandwidth_code == 8'h1f && enMotion == 8'h00) // [R13]
        else $error("soft reset did not restore defaults");
    soft_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst) rdStrobe && isIdx(paddr, `IDX_SOFT_RESET) |-> prdata == 32'h0) // [R14]
        else $error("soft reset register read nonzero");
    bad_range_a: assert property (@(posedge sys_clk) disable iff (sys_rst) !(fullScale[3:0] inside {4'h5, 4'h8, 4'hc}) |=> gRange == accel_cfg_pkg::RANGE_2G) // [R2]
        else $error("irregular range not 2g");
    reserved_bits_a: assert property (@(posedge sys_clk) disable iff (sys_rst) (filter_bandwidth_code[7:5] == 3'h0) && (powerMode[0] == 1'b0) && (enLevel[7:5] == 3'h0)) // [R26]
        else $error("reserved bit set");
    pin_quiet_a: assert property (@(posedge sys_clk) disable iff (sys_rst) (pinOneRoute == 8'h0 && !newSampleRoute[0] && pinLevelCfg[0]) [*2] |-> !irq_pin_one) // [R25]
        else $error("unmapped pin one asserted");
    suspend_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R7]
        powerMode[`BIT_SUSPEND] && !softReset |=> powerState == accel_cfg_pkg::PWR_SUSPEND)
        else $error("suspend not entered");
    shadow_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) !acquisition[6] && !rdStrobe && !softReset |=> $stable(msbShadow[0])) // [R12]
        else $error("msb changed without lsb read");

endmodule

// ---- dv/apb_host_model.sv ----
`timescale 1ns/1ps
module apb_host_model (
    input  wire logic        sys_clk,
    input  wire logic        pready,
    output logic      [7:0]  paddr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    end
    // setup, then access held until pready; bounded so a dead slave cannot hang the run
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output bit ok);
        ok = 1'b0;
        @(posedge sys_clk);
        {paddr, pwrite, pwdata, pstrb, psel} <= {a, w, d, 4'hf, 1'b1};
        @(posedge sys_clk);
        penable <= 1'b1;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge sys_clk);
            ok = (pready === 1'b1);
        end
        // released lines carry junk so a slave cannot lean on stale values
        {paddr, pwdata, pstrb, psel, penable} <= {~a, ~d, 4'h0, 2'b00};
    endtask
endmodule

// ---- dv/accel_config_irq_routing_tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module accel_config_irq_routing_tb;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  paddr;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [29:0] filteredSample = '0;
    logic [29:0] unfilteredSample = '0;
    logic        sampleStrobe = 1'b0;
    logic [7:0]  motionStatus = '0;
    logic        newSampleStatus = 1'b0;
    logic        irq_pin_one, irq_pin_two, sleepPhase;
    logic [1:0]  gRange, powerState;
    logic [2:0]  bandwidth;
    int          n_fail = 0;
    int          checks_done = 0;
    logic [32:0] expQ[$];
    logic [7:0]  rIdx[10] = '{8'h0f, 8'h10, 8'h11, 8'h13, 8'h16, 8'h17, 8'h19, 8'h1a, 8'h1b, 8'h20};
    logic [7:0]  rMask[10] = '{8'h0f, 8'h1f, 8'hde, 8'hc0, 8'hf7, 8'h1f, 8'hf7, 8'h81, 8'hf7, 8'h05};
    logic [7:0]  rRst[10] = '{8'h03, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05};
    logic [7:0]  resv[4] = '{8'h12, 8'h14, 8'h15, 8'h18};
    logic [1:0]  rngT[16] = '{3: 0, 5: 1, 8: 2, 12: 3, default: 0};
    logic [3:0]  bitPos[7] = '{7, 6, 5, 4, 2, 1, 0};
    logic [7:0]  enM[7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h07, 8'h00, 8'h00};
    logic [7:0]  enL[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h08};

    always #25 sys_clk = ~sys_clk;

    accel_config_irq_routing uut (
        .sys_clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .filteredSample, .unfilteredSample, .sampleStrobe, .motionStatus, .newSampleStatus,
        .irq_pin_one, .irq_pin_two, .gRange, .bandwidth, .powerState, .sleepPhase
    );
    apb_host_model host (.sys_clk, .pready, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb);

    // each completed transfer takes the oldest note
    always @(posedge sys_clk) begin
        logic [32:0] e;
        if (psel && penable && pready) begin
            e = expQ.pop_front();
            `CHK("pslverr", e[32], pslverr)
            if (!pwrite && !e[32]) `CHK("prdata", e[31:0], prdata)
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic acc(input logic [7:0] idx, input logic w, input logic [31:0] d, input logic err = 1'b0,
                       input logic [1:0] lo = 2'b00);
        bit ok;
        expQ.push_back({err, d});
        host.xfer({idx[5:0], lo}, w, d, ok);
        if (!ok) begin
            n_fail++;
            test_done();
        end
    endtask

    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic pins(input logic one, input logic two);
        settle();
        `CHK("irq_pin_one", one, irq_pin_one)
        `CHK("irq_pin_two", two, irq_pin_two)
    endtask

    task automatic strobe();
        @(posedge sys_clk);
        sampleStrobe <= 1'b1;
        @(posedge sys_clk);
        sampleStrobe <= 1'b0;
    endtask

    initial begin
        logic [31:0] v;
        logic [29:0] a;
        int          n;
        v = $urandom(18444);
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        pins(1'b0, 1'b0);
        `CHK("gRange", 2'd0, gRange)
        `CHK("bandwidth", 3'd6, bandwidth)
        `CHK("powerState", 2'd0, powerState)
        for (int i = 0; i < 10; i++) acc(rIdx[i], 1'b0, {24'h0, rRst[i]});
        for (int i = 0; i < 4; i++) acc(resv[i], 1'b0, 32'h0);
        acc(8'h21, 1'b0, 32'h0, 1'b1);
        acc(8'h0f, 1'b1, 32'h0c, 1'b1, 2'b01);
        acc(8'h0f, 1'b0, 32'h03);
        $display("test reset_defaults done");
        for (int i = 0; i < 10; i++) begin
            v = $urandom();
            acc(rIdx[i], 1'b1, v);
            acc(rIdx[i], 1'b0, {24'h0, v[7:0] & rMask[i]});
        end
        acc(8'h0f, 1'b1, 32'h05);
        acc(8'h14, 1'b1, 32'hb7);
        acc(8'h0f, 1'b0, 32'h05);
        acc(8'h14, 1'b1, 32'hb6);
        for (int i = 0; i < 10; i++) acc(rIdx[i], 1'b0, {24'h0, rRst[i]});
        $display("test readback_softreset done");
        for (int c = 0; c < 16; c++) begin
            acc(8'h0f, 1'b1, c);
            settle();
            `CHK("gRange", rngT[c], gRange)
        end
        // every code, also those a host is advised to avoid
        for (int c = 0; c < 32; c++) begin
            acc(8'h10, 1'b1, c);
            settle();
            `CHK("bandwidth", 3'((c > 13) ? 6 : ((c > 8) ? c - 8 : 0)), bandwidth)
        end
        for (int k = 0; k < 3; k++) begin
            acc(8'h11, 1'b1, 32'h80 >> k);
            settle();
            `CHK("powerState", 2'(2 - k), powerState)
        end
        // shortest sleep: 0.5 ms at 20 MHz is 10000 cycles, one of them awake
        acc(8'h11, 1'b1, 32'h40);
        n = 0;
        for (int t = 0; t < 25000 && !(n > 0 && sleepPhase !== 1'b1); t++) begin
            @(posedge sys_clk);
            #1;
            if (sleepPhase === 1'b1) n++;
        end
        `CHK("sleep cycles", 9999, n)
        acc(8'h11, 1'b1, 32'h00);
        $display("test decode done");
        a = 30'($urandom());
        @(posedge sys_clk);
        filteredSample <= a;
        strobe();
        acc(8'h02, 1'b0, {24'h0, a[1:0], 5'h0, 1'b1});
        acc(8'h02, 1'b0, {24'h0, a[1:0], 5'h0, 1'b0});
        @(posedge sys_clk);
        filteredSample <= ~a;
        acc(8'h03, 1'b0, {24'h0, a[9:2]});
        acc(8'h13, 1'b1, 32'h80);
        @(posedge sys_clk);
        unfilteredSample <= a;
        strobe();
        acc(8'h04, 1'b0, {24'h0, a[11:10], 5'h0, 1'b1});
        acc(8'h05, 1'b0, {24'h0, a[19:12]});
        acc(8'h13, 1'b1, 32'h40);
        @(posedge sys_clk);
        filteredSample <= a;
        strobe();
        acc(8'h07, 1'b0, {24'h0, a[29:22]});
        $display("test sample_path done");
        @(posedge sys_clk);
        motionStatus <= 8'hf7;
        for (int k = 0; k < 7; k++) begin
            v = 32'h1 << bitPos[k];
            acc(8'h16, 1'b1, enM[k]);
            acc(8'h17, 1'b1, enL[k]);
            acc(8'h19, 1'b1, v);
            acc(8'h1b, 1'b1, ~v & 32'hf7);
            pins(1'b1, 1'b0);
            acc(8'h19, 1'b1, ~v & 32'hf7);
            acc(8'h1b, 1'b1, v);
            pins(1'b0, 1'b1);
        end
        @(posedge sys_clk);
        motionStatus <= 8'h00;
        newSampleStatus <= 1'b1;
        acc(8'h17, 1'b1, 32'h10);
        acc(8'h1a, 1'b1, 32'h80);
        pins(1'b0, 1'b1);
        acc(8'h1a, 1'b1, 32'h01);
        pins(1'b1, 1'b0);
        acc(8'h20, 1'b1, 32'h00);
        pins(1'b0, 1'b1);
        $display("test irq_routing done");
        test_done();
    end
endmodule
